// ### sys_pll_ctrl.sv
// System clock PLL configuration, lock detector and stability status
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sys_pll_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vco_cal_done,
    input wire logic ref_edge,
    input wire logic fb_edge,
    output sys_pll_pkg::pll_cfg_s pll_cfg,
    output sys_pll_pkg::pll_stat_s pll_stat,
    output logic irq
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        sys_pll_pkg::state_e state;
        sys_pll_pkg::pll_cfg_s cfg;
        sys_pll_pkg::pll_stat_s stat;
        logic [31:0] ref_freq;
        logic [15:0] valid_ms;
        logic [2:0] int_status;
        logic [2:0] int_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic pending;
        logic pending_ref;
        logic [7:0] diff_cnt;
        logic [3:0] good_cnt;
    } ctrl_s;

    ctrl_s s;
    ctrl_s next_s;
    logic setup;
    logic wr;
    logic mapped;
    logic sample;
    logic sample_good;
    logic [2:0] events;
    logic [11:0] ratio_x8;
    logic [31:0] rd;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && s.pready;

    // Frequency ratio in eighths, so the prescale division stays integer
    assign ratio_x8 = 12'(({4'h0, s.cfg.fb_div} << (s.cfg.ref_doubler_en ? 4 : 3))
        >> s.cfg.input_prescale_sel);

    always_comb begin
        mapped = 1'b1;
        rd = 32'h0000_0000;
        unique case (paddr)
            sys_pll_pkg::ADDR_CTRL: begin
                rd[sys_pll_pkg::CTRL_OSC_PATH] = s.cfg.osc_path_sel;
                rd[sys_pll_pkg::CTRL_DOUBLER] = s.cfg.ref_doubler_en;
                rd[sys_pll_pkg::CTRL_PRESCALE_LO +: 2] = s.cfg.input_prescale_sel;
            end
            sys_pll_pkg::ADDR_FB_DIV: rd[7:0] = s.cfg.fb_div;
            sys_pll_pkg::ADDR_REF_FREQ: rd = s.ref_freq;
            sys_pll_pkg::ADDR_VALID_MS: rd[15:0] = s.valid_ms;
            sys_pll_pkg::ADDR_CMD: rd = 32'h0000_0000;
            sys_pll_pkg::ADDR_STATUS: begin
                rd[sys_pll_pkg::ST_LOCK] = s.stat.system_clock_pll_lock_flag;
                rd[sys_pll_pkg::ST_STABLE] = s.stat.system_clock_stable;
                rd[sys_pll_pkg::ST_CAL_BUSY] = (s.state == sys_pll_pkg::ST_CAL);
                rd[sys_pll_pkg::ST_STATE_LO +: 4] = s.state;
            end
            sys_pll_pkg::ADDR_RATIO: rd[11:0] = ratio_x8;
            sys_pll_pkg::ADDR_INT_STATUS: rd[2:0] = s.int_status;
            sys_pll_pkg::ADDR_INT_MASK: rd[2:0] = s.int_mask;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_s = s;
        sample = 1'b0;
        sample_good = 1'b0;
        events = 3'h0;
        next_s.stat.vco_cal_req = 1'b0;

        // ****************************************
        // APB slave, answers with no wait state
        // ****************************************
        next_s.pready = setup;
        if (setup) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : rd;
            next_s.pslverr = !mapped;
        end else if (s.pready) begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b0;
        end

        // Status and ratio addresses have no write path
        if (wr && mapped) begin
            unique case (paddr)
                sys_pll_pkg::ADDR_CTRL: begin
                    if (pstrb[0]) begin
                        next_s.cfg.osc_path_sel = pwdata[sys_pll_pkg::CTRL_OSC_PATH];
                        next_s.cfg.ref_doubler_en = pwdata[sys_pll_pkg::CTRL_DOUBLER];
                        next_s.cfg.input_prescale_sel =
                            pwdata[sys_pll_pkg::CTRL_PRESCALE_LO +: 2];
                        next_s.cfg.prescale_ratio =
                            4'h1 << pwdata[sys_pll_pkg::CTRL_PRESCALE_LO +: 2];
                        // New settings void the old lock
                        next_s.state = sys_pll_pkg::ST_UNPROG;
                    end
                end
                sys_pll_pkg::ADDR_FB_DIV: begin
                    if (pstrb[0]) begin
                        next_s.cfg.fb_div = pwdata[7:0];
                        next_s.state = sys_pll_pkg::ST_UNPROG;
                    end
                end
                sys_pll_pkg::ADDR_REF_FREQ: begin
                    for (int i = 0; i < 4; i++) begin
                        if (pstrb[i]) begin
                            next_s.ref_freq[8*i +: 8] = pwdata[8*i +: 8];
                        end
                    end
                end
                sys_pll_pkg::ADDR_VALID_MS: begin
                    for (int i = 0; i < 2; i++) begin
                        if (pstrb[i]) begin
                            next_s.valid_ms[8*i +: 8] = pwdata[8*i +: 8];
                        end
                    end
                end
                sys_pll_pkg::ADDR_CMD: begin
                    if (pstrb[0] && pwdata[sys_pll_pkg::CMD_START]) begin
                        next_s.state = sys_pll_pkg::ST_CAL;
                        next_s.stat.vco_cal_req = 1'b1;
                    end
                end
                sys_pll_pkg::ADDR_INT_MASK: begin
                    if (pstrb[0]) begin
                        next_s.int_mask = pwdata[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // ****************************************
        // Sequencer
        // ****************************************
        unique case (s.state)
            sys_pll_pkg::ST_UNPROG: begin
            end
            sys_pll_pkg::ST_CAL: begin
                if (vco_cal_done && !next_s.stat.vco_cal_req) begin
                    next_s.state = sys_pll_pkg::ST_ACQ;
                end
            end
            sys_pll_pkg::ST_ACQ: begin
                if (s.stat.system_clock_pll_lock_flag) begin
                    next_s.state = sys_pll_pkg::ST_RUN;
                end
            end
            sys_pll_pkg::ST_RUN: begin
                if (!s.stat.system_clock_pll_lock_flag) begin
                    next_s.state = sys_pll_pkg::ST_ACQ;
                end
            end
            default: next_s.state = sys_pll_pkg::ST_UNPROG;
        endcase
        // A register write above takes priority over the sequencer
        if (wr && mapped && (paddr == sys_pll_pkg::ADDR_CTRL ||
                paddr == sys_pll_pkg::ADDR_FB_DIV || paddr == sys_pll_pkg::ADDR_CMD)
                && pstrb[0]) begin
            if (paddr != sys_pll_pkg::ADDR_CMD || pwdata[sys_pll_pkg::CMD_START]) begin
                next_s.state = (paddr == sys_pll_pkg::ADDR_CMD) ?
                    sys_pll_pkg::ST_CAL : sys_pll_pkg::ST_UNPROG;
            end
        end

        // ****************************************
        // Lock detector: edge-to-edge time difference
        // ****************************************
        if (s.stat.pll_acquire_en) begin
            if (s.pending) begin
                next_s.diff_cnt = s.diff_cnt + 8'h01;
            end
            if (ref_edge && fb_edge) begin
                sample = 1'b1;
                sample_good = !s.pending;
                next_s.pending = 1'b0;
            end else if (ref_edge || fb_edge) begin
                if (s.pending && (s.pending_ref != ref_edge)) begin
                    sample = 1'b1;
                    sample_good = (s.diff_cnt <= sys_pll_pkg::LOCK_WINDOW);
                    next_s.pending = 1'b0;
                end else begin
                    // Same edge twice means a missed partner
                    sample = s.pending;
                    next_s.pending = 1'b1;
                    next_s.pending_ref = ref_edge;
                    next_s.diff_cnt = 8'h00;
                end
            end else if (s.pending && s.diff_cnt == sys_pll_pkg::EDGE_TIMEOUT) begin
                sample = 1'b1;
                next_s.pending = 1'b0;
            end
        end else begin
            next_s.pending = 1'b0;
            next_s.diff_cnt = 8'h00;
            next_s.good_cnt = 4'h0;
            next_s.stat.system_clock_pll_lock_flag = 1'b0;
        end
        if (sample) begin
            if (sample_good) begin
                if (s.good_cnt == sys_pll_pkg::LOCK_COUNT) begin
                    next_s.stat.system_clock_pll_lock_flag = 1'b1;
                end else begin
                    next_s.good_cnt = s.good_cnt + 4'h1;
                end
            end else begin
                next_s.good_cnt = 4'h0;
                next_s.stat.system_clock_pll_lock_flag = 1'b0;
            end
        end

        next_s.stat.pll_acquire_en = (next_s.state == sys_pll_pkg::ST_ACQ) ||
            (next_s.state == sys_pll_pkg::ST_RUN);
        if (!next_s.stat.pll_acquire_en) begin
            next_s.stat.system_clock_pll_lock_flag = 1'b0;
        end
        // Stable only after programming, calibration and lock
        next_s.stat.system_clock_stable = (next_s.state == sys_pll_pkg::ST_RUN) &&
            next_s.stat.system_clock_pll_lock_flag;

        // ****************************************
        // Interrupts: set wins over write-one clear
        // ****************************************
        events[sys_pll_pkg::INT_LOCK_GAIN] = next_s.stat.system_clock_pll_lock_flag &&
            !s.stat.system_clock_pll_lock_flag;
        events[sys_pll_pkg::INT_LOCK_LOST] = !next_s.stat.system_clock_pll_lock_flag &&
            s.stat.system_clock_pll_lock_flag;
        events[sys_pll_pkg::INT_STABLE] = next_s.stat.system_clock_stable &&
            !s.stat.system_clock_stable;
        if (wr && paddr == sys_pll_pkg::ADDR_INT_STATUS && pstrb[0]) begin
            next_s.int_status = s.int_status & ~pwdata[2:0];
        end
        next_s.int_status = next_s.int_status | events;
        next_s.irq = |(next_s.int_status & next_s.int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.state <= sys_pll_pkg::ST_UNPROG;
            s.cfg.osc_path_sel <= 1'b0;
            s.cfg.ref_doubler_en <= 1'b0;
            s.cfg.input_prescale_sel <= 2'h0;
            s.cfg.prescale_ratio <= 4'h1;
            s.cfg.fb_div <= sys_pll_pkg::FB_DIV_RST;
            s.stat <= '0;
            s.ref_freq <= sys_pll_pkg::REF_FREQ_RST;
            s.valid_ms <= sys_pll_pkg::VALID_MS_RST;
            s.int_status <= 3'h0;
            s.int_mask <= sys_pll_pkg::INT_MASK_RST;
            s.irq <= 1'b0;
            s.prdata <= 32'h0000_0000;
            s.pready <= 1'b0;
            s.pslverr <= 1'b0;
            s.pending <= 1'b0;
            s.pending_ref <= 1'b0;
            s.diff_cnt <= 8'h00;
            s.good_cnt <= 4'h0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pll_cfg = s.cfg;
    assign pll_stat = s.stat;
    assign irq = s.irq;
endmodule

// ### sys_pll_ctrl_properties.sv
// Concurrent checks of the system clock PLL control block
`timescale 1ns/1ps
module sys_pll_ctrl_properties (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic vco_cal_done,
    input logic ref_edge,
    input logic fb_edge,
    input sys_pll_pkg::pll_cfg_s pll_cfg,
    input sys_pll_pkg::pll_stat_s pll_stat
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************************************
    // Properties
    // ****************************************
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_ERR: assert property (pslverr |-> pready && (paddr > 8'h20 || paddr[1:0] != 2'b00))
        else $error("pslverr on mapped address");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    AST_PRESCALE: assert property (
        pll_cfg.prescale_ratio == 4'(4'h1 << pll_cfg.input_prescale_sel))
        else $error("prescale ratio not a power of two of the field");
    AST_CAL_PULSE: assert property (pll_stat.vco_cal_req |=> !pll_stat.vco_cal_req)
        else $error("calibration request longer than one cycle");
    AST_ACQ: assert property (
        $rose(pll_stat.pll_acquire_en) |-> $past(vco_cal_done) || $past(vco_cal_done, 2))
        else $error("acquire started without calibration done");
    AST_STABLE_RISE: assert property (
        $rose(pll_stat.system_clock_stable) |-> $past(pll_stat.system_clock_pll_lock_flag))
        else $error("stable rose without lock");
    // Stable only with a live lock inside the acquire window
    AST_STABLE_DROP: assert property (
        pll_stat.system_clock_stable |->
            pll_stat.system_clock_pll_lock_flag && pll_stat.pll_acquire_en)
        else $error("stable kept after lock loss");
    // Lock is set by the sample taken on the closing edge one cycle before
    AST_LOCK_EDGE: assert property (
        $rose(pll_stat.system_clock_pll_lock_flag) |-> $past(ref_edge || fb_edge))
        else $error("lock set without edge comparison");
    AST_CTRL_DROP: assert property (
        psel && penable && pready && pwrite && paddr == sys_pll_pkg::ADDR_CTRL && pstrb[0]
            |-> ##[1:2] !pll_stat.system_clock_stable)
        else $error("stable kept after control write");
endmodule
bind sys_pll_ctrl sys_pll_ctrl_properties props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vco_cal_done(vco_cal_done), .ref_edge(ref_edge), .fb_edge(fb_edge),
    .pll_cfg(pll_cfg), .pll_stat(pll_stat)
);

// ### sys_pll_ctrl_tb_top.sv
// Self-checking testbench of the system clock PLL control block
`timescale 1ns/1ps
module sys_pll_ctrl_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic vco_cal_done = 0, ref_edge = 0, fb_edge = 0, pready, pslverr, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF, strb = 4'hF;
    sys_pll_pkg::pll_cfg_s pll_cfg;
    sys_pll_pkg::pll_stat_s pll_stat;
    int err_count = 0, checks = 0;
    initial forever #2.5 pclk = ~pclk;
    sys_pll_ctrl sys_pll_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .vco_cal_done(vco_cal_done),
        .ref_edge(ref_edge), .fb_edge(fb_edge), .pll_cfg(pll_cfg), .pll_stat(pll_stat),
        .irq(irq));
    // ****************************************
    // Bus, compare and closing tasks
    // ****************************************
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    // Waits on a registered flag; sampled mid-cycle so it is settled
    task automatic wait_hi(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? pll_stat.vco_cal_req : pll_stat.system_clock_stable) !== 1'b1) begin
            @(negedge pclk);
            n++;
            if (n > 200) begin
                err_count++;
                test_done();
            end
        end
    endtask
    task automatic edges(input logic r, input logic f, input int n);
        repeat (n) begin
            @(posedge pclk);
            ref_edge <= r;
            fb_edge <= f;
            @(posedge pclk);
            ref_edge <= 1'b0;
            fb_edge <= 1'b0;
        end
    endtask
    task automatic t_reset();
        chk("cfg", 32'h0000_0164, 32'(pll_cfg));
        chk("stat", 32'h0, 32'(pll_stat));
        apb(1'b0, sys_pll_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h0000_0010, rd);
        apb(1'b0, sys_pll_pkg::ADDR_FB_DIV, 32'h0);
        chk("fb_div", 32'h0000_0064, rd);
    endtask
    task automatic t_config();
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, sys_pll_pkg::ADDR_CTRL, 32'(s << 2) | 32'h1);
            apb(1'b0, sys_pll_pkg::ADDR_RATIO, 32'h0);
            chk("prescale", 32'(1 << s), 32'(pll_cfg.prescale_ratio));
            chk("path", 32'h1, 32'(pll_cfg.osc_path_sel));
            chk("ratio", 32'((100 * 8) >> s), rd);
        end
        apb(1'b1, sys_pll_pkg::ADDR_FB_DIV, 32'h0000_00FF);
        chk("fb_div", 32'h0000_00FF, 32'(pll_cfg.fb_div));
        apb(1'b1, sys_pll_pkg::ADDR_CTRL, 32'h0000_0002);
        apb(1'b0, sys_pll_pkg::ADDR_RATIO, 32'h0);
        chk("path", 32'h0, 32'(pll_cfg.osc_path_sel));
        chk("ratio", 32'(255 * 16), rd);
        strb = 4'h0;
        apb(1'b1, sys_pll_pkg::ADDR_CTRL, 32'h0);
        strb = 4'hF;
        chk("doubler", 32'h1, 32'(pll_cfg.ref_doubler_en));
        apb(1'b0, sys_pll_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h0000_0002, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        apb(1'b1, sys_pll_pkg::ADDR_VALID_MS, 32'h0001_2345);
        apb(1'b0, sys_pll_pkg::ADDR_VALID_MS, 32'h0);
        chk("valid_ms", 32'h0000_2345, rd);
        apb(1'b1, sys_pll_pkg::ADDR_FB_DIV, 32'h0000_0064);
        apb(1'b1, sys_pll_pkg::ADDR_CTRL, 32'h0);
    endtask
    task automatic t_lock();
        apb(1'b1, sys_pll_pkg::ADDR_REF_FREQ, 32'h02EE_0000);
        apb(1'b0, sys_pll_pkg::ADDR_REF_FREQ, 32'h0);
        chk("ref_freq", 32'h02EE_0000, rd);
        apb(1'b1, sys_pll_pkg::ADDR_CMD, 32'h1);
        wait_hi(0);
        apb(1'b0, sys_pll_pkg::ADDR_STATUS, 32'h0);
        chk("state", 32'h2, 32'(rd[7:4]));
        @(posedge pclk);
        vco_cal_done <= 1'b1;
        @(posedge pclk);
        vco_cal_done <= 1'b0;
        edges(1'b1, 1'b1, 14);
        wait_hi(1);
        chk("acquire", 32'h1, 32'(pll_stat.pll_acquire_en));
        apb(1'b1, sys_pll_pkg::ADDR_STATUS, 32'h0);
        apb(1'b0, sys_pll_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h0000_0083, rd);
        apb(1'b0, sys_pll_pkg::ADDR_INT_STATUS, 32'h0);
        chk("int_status", 32'h5, rd);
        chk("irq", 32'h0, 32'(irq));
        apb(1'b1, sys_pll_pkg::ADDR_INT_MASK, 32'h4);
        repeat (2) @(negedge pclk);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, sys_pll_pkg::ADDR_INT_STATUS, 32'h4);
        apb(1'b1, sys_pll_pkg::ADDR_INT_MASK, 32'h2);
        repeat (2) @(negedge pclk);
        chk("irq", 32'h0, 32'(irq));
        edges(1'b1, 1'b0, 2);
        repeat (4) @(negedge pclk);
        chk("irq", 32'h1, 32'(irq));
        chk("stable", 32'h0, 32'(pll_stat.system_clock_stable));
        apb(1'b0, sys_pll_pkg::ADDR_STATUS, 32'h0);
        chk("lock", 32'h0, 32'(rd[1:0]));
        // Relock with feedback trailing reference, inside the window
        repeat (10) begin
            edges(1'b1, 1'b0, 1);
            edges(1'b0, 1'b1, 1);
        end
        wait_hi(1);
        apb(1'b0, sys_pll_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h0000_0083, rd);
        apb(1'b1, sys_pll_pkg::ADDR_CTRL, 32'h0);
        apb(1'b0, sys_pll_pkg::ADDR_STATUS, 32'h0);
        chk("state", 32'h1, 32'(rd[7:4]));
        chk("stable", 32'h0, 32'(pll_stat.system_clock_stable));
        chk("acquire", 32'h0, 32'(pll_stat.pll_acquire_en));
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset();
        t_config();
        t_lock();
        test_done();
    end
endmodule

// ### sys_pll_pkg.sv
// Constants and types of the system clock PLL control block
package sys_pll_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FB_DIV = 8'h04;
    localparam logic [7:0] ADDR_REF_FREQ = 8'h08;
    localparam logic [7:0] ADDR_VALID_MS = 8'h0C;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_RATIO = 8'h18;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_INT_MASK = 8'h20;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_OSC_PATH = 0;
    localparam int CTRL_DOUBLER = 1;
    localparam int CTRL_PRESCALE_LO = 2;
    localparam int CMD_START = 0;
    localparam int ST_LOCK = 0;
    localparam int ST_STABLE = 1;
    localparam int ST_CAL_BUSY = 2;
    localparam int ST_STATE_LO = 4;
    localparam int INT_LOCK_GAIN = 0;
    localparam int INT_LOCK_LOST = 1;
    localparam int INT_STABLE = 2;
    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [7:0] FB_DIV_RST = 8'h64;
    localparam logic [31:0] REF_FREQ_RST = 32'h0000_0000;
    localparam logic [15:0] VALID_MS_RST = 16'h0000;
    localparam logic [2:0] INT_MASK_RST = 3'h0;
    localparam logic [7:0] LOCK_WINDOW = 8'h02;
    localparam logic [7:0] EDGE_TIMEOUT = 8'hFF;
    localparam logic [3:0] LOCK_COUNT = 4'h8;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        ST_UNPROG = 4'b0001,
        ST_CAL = 4'b0010,
        ST_ACQ = 4'b0100,
        ST_RUN = 4'b1000
    } state_e;
    typedef struct packed {
        logic osc_path_sel;
        logic ref_doubler_en;
        logic [1:0] input_prescale_sel;
        logic [3:0] prescale_ratio;
        logic [7:0] fb_div;
    } pll_cfg_s;
    typedef struct packed {
        logic system_clock_pll_lock_flag;
        logic system_clock_stable;
        logic vco_cal_req;
        logic pll_acquire_en;
    } pll_stat_s;
endpackage
